// >>> verification/sdwap_core_sva.sv
`timescale 1ns/1ps
module sdwap_core_sva
(
	input wire logic i_clk_sys, // clock
	input wire logic i_reset, // reset
	input wire logic i_cs_n, // select
	input wire logic i_ras_n, // row strobe
	input wire logic i_cas_n, // col strobe
	input wire logic i_we_n, // write
	input wire logic [1:0] i_ba, // bank
	input wire logic [11:0] i_addr, // address
	input wire logic o_dq_oe_n, // drive
	input wire logic [3:0] o_bank_open // open rows
);
	default clocking dclk @(posedge i_clk_sys);
	endclocking
	default disable iff (i_reset);
	typedef struct packed
	{
		logic cl2; // latency two
		logic wbm; // single writes
		logic [2:0] bl; // burst code
		logic [3:0] left; // words due
		logic [1:0] wb; // ap write bank
		logic [1:0] cb; // recovering bank
		logic [3:0] age; // edges since read
	} sdwap_chk_s;
	sdwap_chk_s chk_q;
	sdwap_chk_s chk_d;
	wire logic [2:0] cmd = i_cs_n ? sdwap_pkg::CMD_NOP : {i_ras_n, i_cas_n, i_we_n};
	wire logic rd = cmd == sdwap_pkg::CMD_READ;
	wire logic wr = cmd == sdwap_pkg::CMD_WRITE;
	wire logic stop = rd || wr || cmd == sdwap_pkg::CMD_PRE || cmd == sdwap_pkg::CMD_BST;
	wire logic cut = (rd || wr) && chk_q.left != 4'h0 && i_ba != chk_q.wb;
	wire logic done = chk_q.left == 4'h1 && !stop;
	// follow mode and auto-precharge write progress
	always_comb
	begin
		chk_d = chk_q;
		chk_d.age = rd ? 4'h0 : chk_q.age + 4'(chk_q.age != 4'hf);
		chk_d.left = stop || chk_q.left == 4'h0 ? 4'h0 : chk_q.left - 4'h1;
		if (cut || done)
			chk_d.cb = chk_q.wb;
		if (wr && i_addr[sdwap_pkg::AP_BIT])
		begin
			chk_d.wb = i_ba;
			chk_d.left = chk_q.wbm || chk_q.bl > 3'h3 ? 4'h0 : 4'((1 << chk_q.bl) - 1);
		end
		if (cmd == sdwap_pkg::CMD_LMR)
		begin
			chk_d.cl2 = i_addr[6:4] == sdwap_pkg::CL_2;
			chk_d.wbm = i_addr[sdwap_pkg::WBM_BIT];
			chk_d.bl = i_addr[2:0];
		end
	end
	// tracking register
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
			chk_q <= '{1'h0, 1'h0, sdwap_pkg::RST_BL, 4'h0, 2'h0, 2'h0, 4'hf};
		else
			chk_q <= chk_d;
	end
	a_cs_nop: assert property
		(i_cs_n && o_bank_open == 4'h0 |=> o_bank_open == 4'h0)
		else $error("deselected command opened a bank");
	a_cs_quiet: assert property
		(i_cs_n && i_ras_n && !i_cas_n && i_we_n && chk_q.age > 4'ha |=> o_dq_oe_n [*3])
		else $error("deselected read drove data");
	a_rd_two: assert property
		(rd && chk_q.cl2 && chk_q.bl == sdwap_pkg::BL_4 |-> ##2 !o_dq_oe_n [*4] ##1 o_dq_oe_n)
		else $error("read burst timing wrong at latency two");
	a_rd_three: assert property
		(rd && !chk_q.cl2 |-> ##3 !o_dq_oe_n)
		else $error("read data late at latency three");
	a_oe_idle: assert property
		(chk_q.age > 4'ha |-> o_dq_oe_n)
		else $error("data driven with no read");
	a_cut_rec: assert property
		(cut |=> o_bank_open[chk_q.cb] [*4] ##1 !o_bank_open[chk_q.cb])
		else $error("interrupted bank closed at wrong time");
	a_done_rec: assert property
		(done |=> o_bank_open[chk_q.cb] [*4] ##1 !o_bank_open[chk_q.cb])
		else $error("completed bank closed at wrong time");
	a_cut_new: assert property
		(cut |=> o_bank_open[$past(i_ba)])
		else $error("interrupting access not accepted");
endmodule // sdwap_core_sva
bind sdwap_core sdwap_core_sva u_sva
(
	.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cs_n(i_cs_n), .i_ras_n(i_ras_n),
	.i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_ba(i_ba), .i_addr(i_addr),
	.o_dq_oe_n(o_dq_oe_n), .o_bank_open(o_bank_open)
);

// >>> verification/sdwap_ctl.sv
`timescale 1ns/1ps
module sdwap_ctl
#(
	parameter int T_RP_CYC = 3 // row precharge wait
)
(
	input wire logic i_clk_sys, // clock
	output logic o_cs_n, // select
	output logic [2:0] o_cmd, // ras cas we
	output logic [1:0] o_ba, // bank
	output logic [11:0] o_addr, // address
	output logic [15:0] o_dq, // write data
	output logic [1:0] o_dqm // byte write masks
);
	logic [1:0] dqm_next;
	// idle bus at time zero
	initial
	begin
		dqm_next = 2'h0;
		o_dqm = 2'h0;
		o_cs_n = 1'h1;
		o_cmd = sdwap_pkg::CMD_NOP;
		o_ba = 2'h0;
		o_addr = 12'h000;
		o_dq = 16'h0000;
	end
	// one command per falling edge, released data toggles
	task automatic send(input logic cs_n, input logic [2:0] c, input logic [1:0] b,
		input logic [11:0] a, input logic drv, input logic [15:0] d);
		@(negedge i_clk_sys);
		o_cs_n = cs_n;
		o_cmd = c;
		o_ba = b;
		o_addr = a;
		o_dq = drv ? d : ~o_dq;
		o_dqm = dqm_next;
	endtask
	// byte masks applied from the next command on
	task automatic mask(input logic [1:0] m);
		dqm_next = m;
	endtask
	task automatic nop(input logic drv, input logic [15:0] d);
		send(1'h0, sdwap_pkg::CMD_NOP, 2'h0, 12'h000, drv, d);
	endtask
	// mode load ahead of the refresh cycles
	task automatic init(input logic [11:0] mode);
		send(1'h0, sdwap_pkg::CMD_LMR, 2'h0, mode, 1'h0, 16'h0000);
		send(1'h0, sdwap_pkg::CMD_REF, 2'h0, 12'h000, 1'h0, 16'h0000);
		send(1'h0, sdwap_pkg::CMD_REF, 2'h0, 12'h000, 1'h0, 16'h0000);
	endtask
	// open a row after the precharge wait
	task automatic act(input logic [1:0] b);
		repeat (T_RP_CYC) nop(1'h0, 16'h0000);
		send(1'h0, sdwap_pkg::CMD_ACTIVE, b, 12'h000, 1'h0, 16'h0000);
	endtask
endmodule // sdwap_ctl

// >>> verification/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic i_clk_sys;
	logic i_reset;
	logic cs_n;
	logic [2:0] cmd;
	logic [1:0] ba;
	logic [11:0] addr;
	logic [15:0] wdq;
	logic [15:0] rdq;
	logic [3:0] bank_open;
	logic [1:0] dqm;
	logic oe_n;
	int miscompares;
	int total_checks;
	sdwap_ctl u_sdwap_ctl (.i_clk_sys(i_clk_sys), .o_cs_n(cs_n), .o_cmd(cmd), .o_ba(ba),
		.o_addr(addr), .o_dq(wdq), .o_dqm(dqm));
	sdwap_core u_sdwap_core (.i_clk_sys(i_clk_sys), .i_reset(i_reset), .i_cs_n(cs_n),
		.i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]), .i_ba(ba), .i_addr(addr),
		.i_dq(wdq), .i_dqm(dqm), .o_dq(rdq), .o_dq_oe_n(oe_n), .o_bank_open(bank_open));
	initial
	begin
		i_clk_sys = 1'h0;
		forever #2 i_clk_sys = ~i_clk_sys;
	end
	task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// burst write from column 0, n words
	task automatic wr(input logic [1:0] b, input logic ap, input logic [15:0] d, input int n);
		u_sdwap_ctl.send(1'h0, sdwap_pkg::CMD_WRITE, b, {1'h0, ap, 10'h000}, 1'h1, d);
		for (int i = 1; i < n; i++)
			u_sdwap_ctl.nop(1'h1, d + 16'(i));
	endtask
	// read four words from column 0, each checked while it stands
	task automatic rd(input logic [1:0] b, input int cl, input logic [15:0] e [4]);
		u_sdwap_ctl.send(1'h0, sdwap_pkg::CMD_READ, b, 12'h000, 1'h0, 16'h0000);
		for (int i = 0; i < cl + 3; i++)
		begin
			u_sdwap_ctl.nop(1'h0, 16'h0000);
			if (i >= cl - 1)
			begin
				check("read word", rdq, e[i - cl + 1]);
				check("read drive", 16'(oe_n), 16'h0000);
			end
		end
	endtask
	task automatic t_init;
		u_sdwap_ctl.send(1'h1, sdwap_pkg::CMD_ACTIVE, 2'h0, 12'h000, 1'h0, 16'h0000);
		u_sdwap_ctl.send(1'h1, sdwap_pkg::CMD_READ, 2'h0, 12'h000, 1'h0, 16'h0000);
		// a deselected read must never drive the data pins
		repeat (4)
		begin
			u_sdwap_ctl.nop(1'h0, 16'h0000);
			check("idle drive", 16'(oe_n), 16'h0001);
		end
		check("open banks", 16'(bank_open), 16'h0000);
		u_sdwap_ctl.init(12'h022);
		u_sdwap_ctl.act(2'h0);
		u_sdwap_ctl.act(2'h1);
		wr(2'h0, 1'h0, 16'h0a00, 4);
		wr(2'h1, 1'h0, 16'h0b00, 4);
		$display("test init done");
	endtask
	task automatic t_rd_cut;
		wr(2'h0, 1'h1, 16'h1000, 2);
		rd(2'h1, 2, '{16'h0b00, 16'h0b01, 16'h0b02, 16'h0b03});
		check("open banks", 16'(bank_open), 16'h0002);
		u_sdwap_ctl.act(2'h0);
		rd(2'h0, 2, '{16'h1000, 16'h1001, 16'h0a02, 16'h0a03});
		$display("test rd_cut done");
	endtask
	task automatic t_wr_cut;
		wr(2'h0, 1'h1, 16'h2000, 2);
		wr(2'h1, 1'h0, 16'h2100, 4);
		repeat (2) u_sdwap_ctl.nop(1'h0, 16'h0000);
		check("open banks", 16'(bank_open), 16'h0002);
		u_sdwap_ctl.act(2'h0);
		rd(2'h0, 2, '{16'h2000, 16'h2001, 16'h0a02, 16'h0a03});
		rd(2'h1, 2, '{16'h2100, 16'h2101, 16'h2102, 16'h2103});
		$display("test wr_cut done");
	endtask
	task automatic t_done;
		wr(2'h1, 1'h1, 16'h3000, 4);
		repeat (4) u_sdwap_ctl.nop(1'h0, 16'h0000);
		check("open banks", 16'(bank_open), 16'h0003);
		u_sdwap_ctl.nop(1'h0, 16'h0000);
		check("open banks", 16'(bank_open), 16'h0001);
		u_sdwap_ctl.send(1'h0, sdwap_pkg::CMD_LMR, 2'h0, 12'h032, 1'h0, 16'h0000);
		rd(2'h0, 3, '{16'h2000, 16'h2001, 16'h0a02, 16'h0a03});
		$display("test done_cl3 done");
	endtask
	// upper byte masked, burst stopped after two words
	task automatic t_mask;
		u_sdwap_ctl.mask(2'h2);
		wr(2'h0, 1'h0, 16'h4455, 2);
		u_sdwap_ctl.send(1'h0, sdwap_pkg::CMD_BST, 2'h0, 12'h000, 1'h1, 16'h7777);
		u_sdwap_ctl.mask(2'h0);
		rd(2'h0, 3, '{16'h2055, 16'h2056, 16'h0a02, 16'h0a03});
		$display("test mask done");
	endtask
	// reset, then the scenarios in order
	initial
	begin
		i_reset = 1'h1;
		miscompares = 0;
		total_checks = 0;
		repeat (5) @(posedge i_clk_sys);
		@(negedge i_clk_sys);
		i_reset = 1'h0;
		t_init;
		t_rd_cut;
		t_wr_cut;
		t_done;
		t_mask;
		end_sim;
	end
	// watchdog
	initial
	begin
		repeat (2000) @(posedge i_clk_sys);
		miscompares++;
		end_sim;
	end
endmodule // testbench

// >>> verilog/sdwap_core.sv
// Behaviour
// - registered read to another bank stops the auto-precharge write at once
// - interrupting read drives first data cas latency clocks after the command
// - interrupted bank precharges after write recovery counted from the read
// - last word kept is the one registered one clock before the read
// - registered write to another bank ends the auto-precharge write at once
// - interrupted bank precharges after write recovery counted from the new write
// - last word kept is the one registered one clock before the new write
// - select sampled high makes any command a no-operation
// - auto-precharge read closes its row when the burst completes, a write after write recovery
// - read or write to another bank accepted during auto-precharge access
`timescale 1ns/1ps
module sdwap_core
(
	input wire logic i_clk_sys, // system clock
	input wire logic i_reset, // async reset, high
	input wire logic i_cs_n, // chip select, low
	input wire logic i_ras_n, // row strobe, low
	input wire logic i_cas_n, // column strobe, low
	input wire logic i_we_n, // write enable, low
	input wire logic [1:0] i_ba, // bank address
	input wire logic [11:0] i_addr, // address bus
	input wire logic [15:0] i_dq, // data pin input
	input wire logic [1:0] i_dqm, // byte write masks
	output logic [15:0] o_dq, // data pin output
	output logic o_dq_oe_n, // data pin enable, low drives
	output logic [3:0] o_bank_open // banks with a row open
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic act;
		logic [1:0] bank;
		logic [7:0] start;
		logic [7:0] idx;
		logic ap;
	} sdwap_burst_s;

	typedef struct packed {
		logic [2:0] bl;
		logic bt;
		logic [2:0] cl;
		logic wbm;
		logic [3:0] open;
		logic [3:0] pend;
		logic [3:0][3:0] pcnt;
		sdwap_burst_s wr;
		sdwap_burst_s rd;
		logic v0;
		logic v1;
		logic [15:0] d1;
		logic v2;
		logic [15:0] d2;
	} sdwap_state_s;

	sdwap_state_s s_q;
	sdwap_state_s s_d;
	logic [15:0] rd_word;
	logic mem_we;
	logic [9:0] mem_wa;
	logic [9:0] mem_ra;
	logic rd_en;
	logic [2:0] cmd;
	logic new_rw;

	// column mask for a burst length code
	function automatic logic [7:0] len_mask(input logic [2:0] bl);
		case (bl)
			sdwap_pkg::BL_1: len_mask = 8'h00;
			sdwap_pkg::BL_2: len_mask = 8'h01;
			sdwap_pkg::BL_4: len_mask = 8'h03;
			sdwap_pkg::BL_8: len_mask = 8'h07;
			default: len_mask = 8'hff;
		endcase
	endfunction

	// column of element idx, wrapping inside the burst window
	function automatic logic [7:0] col_of(input logic [7:0] start, input logic [7:0] idx,
		input logic [7:0] m, input logic bt);
		logic [7:0] off;
		off = bt ? (start ^ idx) : 8'(start + idx);
		col_of = (start & ~m) | (off & m);
	endfunction

	// ****************************************************************
	// storage
	// ****************************************************************
	sdwap_mem u_mem
	(
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_wr_en(mem_we),
		.i_wr_addr(mem_wa),
		.i_wr_data(i_dq),
		.i_wr_be(~i_dqm),
		.i_rd_addr(mem_ra),
		.o_rd_data(rd_word)
	);

	// command decode, deselect forces nop
	assign cmd = i_cs_n ? sdwap_pkg::CMD_NOP : {i_ras_n, i_cas_n, i_we_n};
	assign new_rw = (cmd == sdwap_pkg::CMD_READ) || (cmd == sdwap_pkg::CMD_WRITE);

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb
	begin
		logic [7:0] rmask;
		logic [7:0] wmask;
		logic [7:0] acol;
		logic stop_all;
		rmask = len_mask(s_q.bl);
		wmask = s_q.wbm ? 8'h00 : rmask;
		acol = i_addr[7:0];
		stop_all = (cmd == sdwap_pkg::CMD_BST);
		s_d = s_q;
		mem_we = 1'b0;
		mem_wa = 10'h000;
		mem_ra = 10'h000;
		rd_en = 1'b0;

		// recovery counters, precharge when expired
		for (int b = 0; b < sdwap_pkg::NBANK; b++)
		begin
			if (s_q.pend[b])
			begin
				if (s_q.pcnt[b] == 4'h0)
				begin
					s_d.pend[b] = 1'b0;
					s_d.open[b] = 1'b0;
				end
				else
					s_d.pcnt[b] = s_q.pcnt[b] - 4'h1;
			end
		end

		// running write burst, held off by a new access or stop
		if (s_q.wr.act && !new_rw && !stop_all)
		begin
			mem_we = 1'b1;
			mem_wa = {s_q.wr.bank, col_of(s_q.wr.start, s_q.wr.idx, wmask, s_q.bt)};
			if (s_q.wr.idx == wmask && wmask != 8'hff)
			begin
				s_d.wr.act = 1'b0;
				if (s_q.wr.ap)
				begin
					s_d.pend[s_q.wr.bank] = 1'b1;
					s_d.pcnt[s_q.wr.bank] = sdwap_pkg::TWR_LOAD;
				end
			end
			else
				s_d.wr.idx = s_q.wr.idx + 8'h01;
		end

		// running read burst
		if (s_q.rd.act && !new_rw && !stop_all)
		begin
			rd_en = 1'b1;
			mem_ra = {s_q.rd.bank, col_of(s_q.rd.start, s_q.rd.idx, rmask, s_q.bt)};
			if (s_q.rd.idx == rmask && rmask != 8'hff)
			begin
				s_d.rd.act = 1'b0;
				if (s_q.rd.ap)
				begin
					s_d.pend[s_q.rd.bank] = 1'b1;
					s_d.pcnt[s_q.rd.bank] = 4'h0;
				end
			end
			else
				s_d.rd.idx = s_q.rd.idx + 8'h01;
		end

		// a new access ends the running bursts; old bank recovers
		if (new_rw)
		begin
			if (s_q.wr.act && s_q.wr.ap)
			begin
				s_d.pend[s_q.wr.bank] = 1'b1;
				s_d.pcnt[s_q.wr.bank] = sdwap_pkg::TWR_LOAD;
			end
			if (s_q.rd.act && s_q.rd.ap)
			begin
				s_d.pend[s_q.rd.bank] = 1'b1;
				s_d.pcnt[s_q.rd.bank] = 4'h0;
			end
			s_d.wr.act = 1'b0;
			s_d.rd.act = 1'b0;
		end
		if (stop_all)
		begin
			s_d.wr.act = 1'b0;
			s_d.rd.act = 1'b0;
		end

		case (cmd)
			sdwap_pkg::CMD_WRITE:
			begin
				// element 0 is taken with the command itself
				mem_we = 1'b1;
				mem_wa = {i_ba, acol};
				s_d.wr = '{act: (wmask != 8'h00), bank: i_ba, start: acol, idx: 8'h01,
					ap: i_addr[sdwap_pkg::AP_BIT]};
				if (wmask == 8'h00 && i_addr[sdwap_pkg::AP_BIT])
				begin
					s_d.pend[i_ba] = 1'b1;
					s_d.pcnt[i_ba] = sdwap_pkg::TWR_LOAD;
				end
			end
			sdwap_pkg::CMD_READ:
			begin
				rd_en = 1'b1;
				mem_ra = {i_ba, acol};
				s_d.rd = '{act: (rmask != 8'h00), bank: i_ba, start: acol, idx: 8'h01,
					ap: i_addr[sdwap_pkg::AP_BIT]};
				if (rmask == 8'h00 && i_addr[sdwap_pkg::AP_BIT])
				begin
					s_d.pend[i_ba] = 1'b1;
					s_d.pcnt[i_ba] = 4'h0;
				end
			end
			sdwap_pkg::CMD_ACTIVE:
			begin
				s_d.open[i_ba] = 1'b1;
				s_d.pend[i_ba] = 1'b0;
			end
			sdwap_pkg::CMD_PRE:
			begin
				for (int b = 0; b < sdwap_pkg::NBANK; b++)
				begin
					if (i_addr[sdwap_pkg::AP_BIT] || i_ba == 2'(b))
					begin
						s_d.open[b] = 1'b0;
						s_d.pend[b] = 1'b0;
						if (s_q.wr.bank == 2'(b))
							s_d.wr.act = 1'b0;
						if (s_q.rd.bank == 2'(b))
							s_d.rd.act = 1'b0;
					end
				end
			end
			sdwap_pkg::CMD_LMR:
			begin
				// accepted at any point of initialisation
				s_d.bl = i_addr[sdwap_pkg::BL_LSB +: 3];
				s_d.bt = i_addr[sdwap_pkg::BT_BIT];
				s_d.cl = i_addr[sdwap_pkg::CL_LSB +: 3];
				s_d.wbm = i_addr[sdwap_pkg::WBM_BIT];
			end
			default:
			begin
				s_d.cl = s_d.cl;
			end
		endcase

		// read pipeline: memory stage, then one or two output stages
		s_d.v0 = rd_en;
		s_d.v1 = s_q.v0;
		s_d.d1 = rd_word;
		s_d.v2 = s_q.v1;
		s_d.d2 = s_q.d1;
	end

	// ****************************************************************
	// state register
	// ****************************************************************
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
		begin
			s_q <= '0;
			s_q.bl <= sdwap_pkg::RST_BL;
			s_q.cl <= sdwap_pkg::RST_CL;
		end
		else
			s_q <= s_d;
	end

	// output tap chosen by cas latency
	always_comb
	begin
		if (s_q.cl == sdwap_pkg::CL_2)
		begin
			o_dq = s_q.d1;
			o_dq_oe_n = ~s_q.v1;
		end
		else
		begin
			o_dq = s_q.d2;
			o_dq_oe_n = ~s_q.v2;
		end
	end

	assign o_bank_open = s_q.open;

endmodule // sdwap_core

// >>> verilog/sdwap_mem.sv
`timescale 1ns/1ps
module sdwap_mem
(
	input wire logic i_clk_sys, // system clock
	input wire logic i_reset, // async reset, high
	input wire logic i_wr_en, // write strobe
	input wire logic [9:0] i_wr_addr, // {bank, column}
	input wire logic [15:0] i_wr_data, // write word
	input wire logic [1:0] i_wr_be, // byte enables
	input wire logic [9:0] i_rd_addr, // {bank, column}
	output logic [15:0] o_rd_data // registered read word
);

	logic [15:0] mem [0:1023];

	// ****************************************************************
	// byte-lane write
	// ****************************************************************
	always_ff @(posedge i_clk_sys)
	begin
		for (int b = 0; b < 2; b++)
		begin
			if (i_wr_en && i_wr_be[b])
				mem[i_wr_addr][b*8 +: 8] <= i_wr_data[b*8 +: 8];
		end
	end

	// registered read port
	always_ff @(posedge i_clk_sys or posedge i_reset)
	begin
		if (i_reset)
			o_rd_data <= 16'h0000;
		else
			o_rd_data <= mem[i_rd_addr];
	end

endmodule // sdwap_mem

// >>> verilog/sdwap_pkg.sv
package sdwap_pkg;

	// ****************************************************************
	// command encoding of {ras_n, cas_n, we_n}
	// ****************************************************************
	localparam logic [2:0] CMD_NOP = 3'h7;
	localparam logic [2:0] CMD_ACTIVE = 3'h3;
	localparam logic [2:0] CMD_READ = 3'h5;
	localparam logic [2:0] CMD_WRITE = 3'h4;
	localparam logic [2:0] CMD_BST = 3'h6;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_REF = 3'h1;
	localparam logic [2:0] CMD_LMR = 3'h0;

	// ****************************************************************
	// address field positions
	// ****************************************************************
	localparam int AP_BIT = 10; // auto precharge / all banks
	localparam int BL_LSB = 0; // burst length code, 3 bits
	localparam int BT_BIT = 3; // burst type, 1 = interleave
	localparam int CL_LSB = 4; // cas latency code, 3 bits
	localparam int WBM_BIT = 9; // 1 = single-location writes

	// ****************************************************************
	// mode codes and reset values
	// ****************************************************************
	localparam logic [2:0] BL_1 = 3'h0;
	localparam logic [2:0] BL_2 = 3'h1;
	localparam logic [2:0] BL_4 = 3'h2;
	localparam logic [2:0] BL_8 = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [2:0] CL_2 = 3'h2;
	localparam logic [2:0] CL_3 = 3'h3;
	localparam logic [2:0] RST_BL = BL_1;
	localparam logic [2:0] RST_CL = CL_3;

	// ****************************************************************
	// sizes
	// ****************************************************************
	localparam int COL_W = 8; // column address bits per bank
	localparam int DQ_W = 16;
	localparam int NBANK = 4;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_MHZ = 250;
	localparam int T_WR_NS = 14; // write recovery, least time
	localparam int TWR_CYC = (T_WR_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0] TWR_LOAD = 4'(TWR_CYC - 1);

endpackage
